/* rtl/slrc_top.sv */
// Sleep and reset controller top level
`timescale 1ns/1ns
module slrc_top (
    input  wire logic        clk,
    input  wire logic        resetn,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Core side
    input  wire logic        sleep_instr,
    input  wire logic        nvm_busy,
    input  wire logic        irq_any,
    input  wire logic        irq_twi_match,
    input  wire logic        irq_port_async,
    input  wire logic        irq_usb_resume,
    input  wire logic        irq_rtc,
    input  wire logic        irq_display,
    input  wire logic        rtc_enabled,
    input  wire logic        display_enabled,
    output logic             cpu_stall,
    output logic             wake_irq_take,
    output logic             cpu_clk_en,
    output logic             nvm_clk_en,
    output logic             periph_clk_en,
    output logic             rtc_clk_en,
    output logic             display_clk_en,
    output logic             sysosc_run,
    output logic [7:0]       periph_gate_en,
    // Reset side
    input  wire logic        por_req,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        droop_req,
    input  wire logic        droop_enabled,
    input  wire logic        chip_erase,
    input  wire logic        dbg_port_enabled,
    input  wire logic        dbg_reset_req,
    input  wire logic        wdt_timeout,
    input  wire logic        osc_ready,
    input  wire logic        osc_cal_done,
    output logic             sys_reset_n,
    output logic             io_tristate,
    output logic             droop_force_on,
    output logic             droop_lowest_level,
    output logic             fetch_start,
    output logic [15:0]      reset_vector
);

typedef enum logic [3:0] {
    SLRC_ACTIVE = 4'b0001,
    SLRC_WAIT   = 4'b0010,
    SLRC_SLEEP  = 4'b0100,
    SLRC_STALL  = 4'b1000
} slrc_pwr_e;

typedef enum logic [4:0] {
    SLRC_R_HOLD  = 5'b00001,
    SLRC_R_COUNT = 5'b00010,
    SLRC_R_OSC   = 5'b00100,
    SLRC_R_CAL   = 5'b01000,
    SLRC_R_RUN   = 5'b10000
} slrc_rst_e;

////////////////////////////////////////////////////////////////////////////
// Input synchronisers
logic [1:0] pin_s1_r, pin_s2_r;
logic [1:0] pin_nxt;
logic       ext_low_sync, wdt_sync;

always_comb begin
    pin_nxt = {wdt_timeout, ~ext_reset_pin_n};
end

always_ff @(posedge clk) begin
    pin_s1_r <= pin_nxt;
    pin_s2_r <= pin_s1_r;
end

assign ext_low_sync = pin_s2_r[0];
assign wdt_sync     = pin_s2_r[1];

////////////////////////////////////////////////////////////////////////////
// External pin filter and software reset
logic [7:0] ext_cnt_r, ext_cnt_nxt;
logic       ext_req;
logic       swrst_r, swrst_nxt;
logic       wr_hit_ctrl;

always_comb begin
    ext_cnt_nxt = ext_cnt_r;
    if (!ext_low_sync) begin
        ext_cnt_nxt = 8'h00;
    end else if (ext_cnt_r < 8'(slrc_pkg::EXT_MIN_CYC)) begin
        ext_cnt_nxt = ext_cnt_r + 8'h01; // RULE_19
    end
    // Write lands the request at the next edge, reset one cycle after the write
    swrst_nxt = wr_hit_ctrl && avs_writedata[slrc_pkg::SWRST_BIT]; // RULE_21
end

always_ff @(posedge clk) begin
    if (!resetn) begin
        ext_cnt_r <= 8'h00;
        swrst_r   <= 1'b0;
    end else begin
        ext_cnt_r <= ext_cnt_nxt;
        swrst_r   <= swrst_nxt;
    end
end

// Held while pin stays low once filter expired
assign ext_req = ext_cnt_r >= 8'(slrc_pkg::EXT_MIN_CYC); // RULE_19

////////////////////////////////////////////////////////////////////////////
// Reset combine and release sequence
logic       any_req, rst_req_n;
logic [1:0] rel_sync_r;
slrc_rst_e  rst_r, rst_nxt;
logic [7:0] seq_cnt_r, seq_cnt_nxt;

// Debug reset has no software path; only the dbg_reset_req input drives it
assign any_req = por_req | ext_req | droop_req | wdt_sync // RULE_20
               | dbg_reset_req | swrst_r; // RULE_22
assign rst_req_n = ~any_req; // RULE_12

// Assertion asynchronous, release synchronised
always_ff @(posedge clk or negedge rst_req_n) begin
    if (!rst_req_n) begin
        rel_sync_r <= 2'b00; // RULE_24
    end else begin
        rel_sync_r <= {rel_sync_r[0], 1'b1};
    end
end

always_comb begin
    rst_nxt     = rst_r;
    seq_cnt_nxt = seq_cnt_r + 8'h01;
    case (rst_r)
        SLRC_R_HOLD: begin
            seq_cnt_nxt = 8'h00;
            if (rel_sync_r[1]) rst_nxt = SLRC_R_COUNT;
        end
        SLRC_R_COUNT: begin
            if (seq_cnt_r == 8'(slrc_pkg::RSTCNT_CYC - 1)) begin
                rst_nxt     = SLRC_R_OSC; // RULE_15
                seq_cnt_nxt = 8'h00;
            end
        end
        SLRC_R_OSC: begin
            seq_cnt_nxt = 8'h00;
            if (osc_ready) rst_nxt = SLRC_R_CAL; // RULE_15
        end
        SLRC_R_CAL: begin
            if (osc_cal_done &&
                seq_cnt_r >= 8'(slrc_pkg::CAL_CYC - 1)) begin
                rst_nxt = SLRC_R_RUN; // RULE_15
            end
        end
        SLRC_R_RUN: seq_cnt_nxt = 8'h00;
        default:    rst_nxt = SLRC_R_HOLD;
    endcase
    if (!rel_sync_r[1]) begin
        rst_nxt = SLRC_R_HOLD; // RULE_16
    end
end

always_ff @(posedge clk) begin
    if (!resetn) begin
        rst_r     <= SLRC_R_HOLD;
        seq_cnt_r <= 8'h00;
    end else begin
        rst_r     <= rst_nxt;
        seq_cnt_r <= seq_cnt_nxt;
    end
end

// Pins float the moment any request appears, before the clock sees it
assign io_tristate = any_req | (rst_r != SLRC_R_RUN); // RULE_13
assign sys_reset_n = ~any_req & (rst_r == SLRC_R_RUN); // RULE_12
assign fetch_start = (rst_r == SLRC_R_CAL) && (rst_nxt == SLRC_R_RUN);

assign droop_force_on = ~droop_enabled &
                        (chip_erase | dbg_port_enabled); // RULE_18
assign droop_lowest_level = droop_force_on; // RULE_18

////////////////////////////////////////////////////////////////////////////
// Registers
logic [3:0]  sctrl_r, sctrl_nxt;
logic [7:0]  pr_r, pr_nxt;
logic        bootvec_r, bootvec_nxt;
logic [5:0]  flags_r, flags_nxt;
logic [31:0] rdata_r, rdata_nxt;
logic        in_reset;
logic        wr_hit_sleep, wr_hit_pr;

assign in_reset     = (rst_r != SLRC_R_RUN);
assign wr_hit_sleep = avs_write && avs_address == slrc_pkg::ADDR_SLEEP_CTRL;
assign wr_hit_pr    = avs_write && avs_address == slrc_pkg::ADDR_PWR_RED;
assign wr_hit_ctrl  = avs_write && avs_address == slrc_pkg::ADDR_RST_CTRL;
assign avs_waitrequest = 1'b0;

always_comb begin
    sctrl_nxt   = sctrl_r;
    pr_nxt      = pr_r;
    bootvec_nxt = bootvec_r;
    flags_nxt   = flags_r;
    rdata_nxt   = 32'h0000_0000;
    if (wr_hit_sleep) sctrl_nxt = avs_writedata[3:0]; // RULE_23
    if (wr_hit_pr)    pr_nxt    = avs_writedata[7:0]; // RULE_06
    if (wr_hit_ctrl) begin
        bootvec_nxt = avs_writedata[slrc_pkg::BOOTVEC_BIT]; // RULE_14
    end
    // Initial values while reset sequence runs
    if (in_reset) begin
        sctrl_nxt = 4'h0; // RULE_13
        pr_nxt    = slrc_pkg::PWR_RED_RST;
    end
    // Sticky flags, only power-on clears them
    if (por_req) begin
        flags_nxt = 6'h01; // RULE_17
    end else begin
        if (ext_req)       flags_nxt[slrc_pkg::FLG_EXT]   = 1'b1; // RULE_17
        if (droop_req)     flags_nxt[slrc_pkg::FLG_DROOP] = 1'b1;
        if (wdt_sync)      flags_nxt[slrc_pkg::FLG_WDT]   = 1'b1;
        if (dbg_reset_req) flags_nxt[slrc_pkg::FLG_DBG]   = 1'b1;
        if (swrst_r)       flags_nxt[slrc_pkg::FLG_SW]    = 1'b1;
    end
    if (avs_read) begin
        case (avs_address)
            slrc_pkg::ADDR_SLEEP_CTRL: rdata_nxt = {28'h0, sctrl_r};
            slrc_pkg::ADDR_PWR_RED:    rdata_nxt = {24'h0, pr_r};
            slrc_pkg::ADDR_RST_STAT:   rdata_nxt = {26'h0, flags_r};
            slrc_pkg::ADDR_RST_CTRL:   rdata_nxt = {30'h0, bootvec_r, 1'b0};
            default:                   rdata_nxt = 32'h0000_0000;
        endcase
    end
end

// Readdata driven combinationally from rdata_nxt; waitrequest low so data stands in the read cycle
always_ff @(posedge clk) begin
    if (!resetn) begin
        sctrl_r   <= 4'h0;
        pr_r      <= slrc_pkg::PWR_RED_RST;
        bootvec_r <= 1'b0;
        flags_r   <= 6'h01;
        rdata_r   <= 32'h0000_0000;
    end else begin
        sctrl_r   <= sctrl_nxt;
        pr_r      <= pr_nxt;
        bootvec_r <= bootvec_nxt;
        flags_r   <= flags_nxt;
        rdata_r   <= rdata_nxt;
    end
end

always_comb begin
    avs_readdata = rdata_nxt;
end

assign reset_vector = bootvec_r ? slrc_pkg::BOOT_VECTOR
                                : slrc_pkg::APP_VECTOR; // RULE_14

////////////////////////////////////////////////////////////////////////////
// Sleep state machine
slrc_pwr_e  pwr_r, pwr_nxt;
logic [2:0] mode_r, mode_nxt;
logic [2:0] stall_r, stall_nxt;
logic       wake, sleep_en;
logic [2:0] mode_sel;

assign sleep_en = sctrl_r[slrc_pkg::SLEEP_EN_BIT];
assign mode_sel = sctrl_r[slrc_pkg::MODE_LSB +: slrc_pkg::MODE_W];

always_comb begin
    wake = irq_twi_match | irq_port_async | irq_usb_resume; // RULE_08
    case (mode_r)
        slrc_pkg::MODE_IDLE: wake = irq_any; // RULE_07
        slrc_pkg::MODE_PSAVE, slrc_pkg::MODE_ESTBY: begin
            wake = wake | (rtc_enabled & irq_rtc) // RULE_09
                 | (display_enabled & irq_display); // RULE_11
        end
        default: wake = wake; // RULE_10
    endcase
end

always_comb begin
    pwr_nxt   = pwr_r;
    mode_nxt  = mode_r;
    stall_nxt = 3'h0;
    case (pwr_r)
        SLRC_ACTIVE: begin
            if (sleep_instr && sleep_en) begin
                mode_nxt = mode_sel; // RULE_01
                pwr_nxt  = (mode_sel == slrc_pkg::MODE_IDLE)
                         ? SLRC_WAIT : SLRC_SLEEP;
            end
        end
        // Memory clock kept until programming completes
        SLRC_WAIT: begin
            if (wake)           pwr_nxt = SLRC_STALL;
            else if (!nvm_busy) pwr_nxt = SLRC_SLEEP; // RULE_07
        end
        SLRC_SLEEP: if (wake) pwr_nxt = SLRC_STALL; // RULE_02
        SLRC_STALL: begin
            stall_nxt = stall_r + 3'h1;
            if (stall_r == 3'(slrc_pkg::WAKE_STALL_CYC - 1)) begin
                pwr_nxt = SLRC_ACTIVE; // RULE_04
            end
        end
        default: pwr_nxt = SLRC_ACTIVE;
    endcase
    if (in_reset) pwr_nxt = SLRC_ACTIVE; // RULE_05
end

always_ff @(posedge clk) begin
    if (!resetn) begin
        pwr_r   <= SLRC_ACTIVE;
        mode_r  <= slrc_pkg::MODE_IDLE;
        stall_r <= 3'h0;
    end else begin
        pwr_r   <= pwr_nxt;
        mode_r  <= mode_nxt;
        stall_r <= stall_nxt;
    end
end

// Pending interrupts are ordered by the interrupt controller on release
assign cpu_stall     = in_reset | (pwr_r != SLRC_ACTIVE); // RULE_04
assign wake_irq_take = (pwr_r == SLRC_STALL) && (pwr_nxt == SLRC_ACTIVE); // RULE_03

////////////////////////////////////////////////////////////////////////////
// Clock gating per mode
logic sleeping, idle_m, save_m, stby_m;

assign sleeping = (pwr_r == SLRC_SLEEP);
assign idle_m   = mode_r == slrc_pkg::MODE_IDLE;
assign save_m   = mode_r == slrc_pkg::MODE_PSAVE ||
                  mode_r == slrc_pkg::MODE_ESTBY;
assign stby_m   = mode_r == slrc_pkg::MODE_STBY ||
                  mode_r == slrc_pkg::MODE_ESTBY;

assign cpu_clk_en     = ~sleeping & (pwr_r != SLRC_WAIT);
assign nvm_clk_en     = ~sleeping; // RULE_07
assign periph_clk_en  = ~sleeping | idle_m; // RULE_07
assign rtc_clk_en     = ~sleeping | idle_m | (save_m & rtc_enabled); // RULE_09
assign display_clk_en = ~sleeping | idle_m | (save_m & display_enabled);
assign sysosc_run     = ~sleeping | idle_m | stby_m; // RULE_10

genvar gi;
generate
    for (gi = 0; gi < slrc_pkg::NPERIPH; gi++) begin : g_gate
        // Gated peripheral holds its state frozen
        assign periph_gate_en[gi] = periph_clk_en & ~pr_r[gi]; // RULE_06
    end
endgenerate

endmodule

/* rtl/slrc_pkg.sv */
// Package: constants for the sleep and reset controller
// Functional notes
// RULE_01: Low-power modes are entered only from active mode on the sleep instruction.
// RULE_02: Enabled interrupt wakes device; handler runs, then execution resumes after sleep.
// RULE_03: Pending higher-priority handlers run before the wake-up interrupt handler.
// RULE_04: CPU is stalled four cycles after any wake-up.
// RULE_05: State kept through sleep; reset during sleep restarts at reset vector.
// RULE_06: Gated peripheral clock freezes that peripheral, in active and idle modes.
// RULE_07: Idle stops CPU and memory clocks after programming; any enabled interrupt wakes.
// RULE_08: Power-down stops all clocks; only address match, port, USB resume wake.
// RULE_09: Power-save is power-down plus running counter and display wake sources.
// RULE_10: Standby is power-down with system clock sources kept oscillating.
// RULE_11: Extended standby is power-save with system clock sources kept oscillating.
// RULE_12: Any reset source resets at once; held until all sources release.
// RULE_13: Reset tri-states pins, loads reset vector, initialises I/O registers.
// RULE_14: Reset vector is address 0, or boot section start by option.
// RULE_15: After release: counter delay, oscillator startup, calibration, then fetch.
// RULE_16: A new reset request during release restarts the sequence.
// RULE_17: One sticky flag per reset source, cleared only by power-on reset.
// RULE_18: Disabled droop detector forced on, lowest level, in erase or debug.
// RULE_19: External reset after pin low beyond minimum pulse; held while low.
// RULE_20: Watchdog timeout gives reset pulse of one to two 2MHz cycles.
// RULE_21: Software reset bit write resets within two cycles, no instruction between.
// RULE_22: Debug port reset only from external programmer, never from software.
// RULE_23: Mode field with enable bit selects the low-power mode.
// RULE_24: Reset sources ORed; assertion asynchronous, release synchronised.
package slrc_pkg;
    // Register map, word aligned byte addresses
    localparam logic [3:0] ADDR_SLEEP_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PWR_RED    = 4'h4;
    localparam logic [3:0] ADDR_RST_STAT   = 4'h8;
    localparam logic [3:0] ADDR_RST_CTRL   = 4'hc;
    // Sleep control and reset control fields
    localparam int SLEEP_EN_BIT  = 0;
    localparam int MODE_LSB      = 1;
    localparam int MODE_W        = 3;
    localparam int SWRST_BIT     = 0;
    localparam int BOOTVEC_BIT   = 1;
    // Mode encodings
    localparam logic [2:0] MODE_IDLE   = 3'h0;
    localparam logic [2:0] MODE_PDOWN  = 3'h2;
    localparam logic [2:0] MODE_PSAVE  = 3'h3;
    localparam logic [2:0] MODE_STBY   = 3'h6;
    localparam logic [2:0] MODE_ESTBY  = 3'h7;
    // Reset flag positions, peripheral count, power reduction reset value and vectors
    localparam int NSRC      = 6;
    localparam int FLG_POR   = 0;
    localparam int FLG_EXT   = 1;
    localparam int FLG_DROOP = 2;
    localparam int FLG_WDT   = 3;
    localparam int FLG_DBG   = 4;
    localparam int FLG_SW    = 5;
    localparam int NPERIPH   = 8;
    localparam logic [7:0]  PWR_RED_RST = 8'h00;
    localparam logic [15:0] BOOT_VECTOR = 16'h8000;
    localparam logic [15:0] APP_VECTOR  = 16'h0000;
    // Timing
    localparam int CLK_MHZ        = 25;
    localparam int WAKE_STALL_CYC = 4;
    localparam int EXT_MIN_NS     = 1000;
    localparam int EXT_MIN_CYC    = (EXT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RSTCNT_CYC     = 64;
    localparam int OSCUP_CYC      = 32;
    localparam int CAL_CYC        = 16;
endpackage

/* tb/slrc_asserts.sv */
// Checker for the sleep and reset controller ports
`timescale 1ns/1ns
module slrc_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        irq_any,
    input wire logic        rtc_enabled,
    input wire logic        cpu_stall,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        rtc_clk_en,
    input wire logic [7:0]  periph_gate_en,
    input wire logic        por_req,
    input wire logic        droop_enabled,
    input wire logic        chip_erase,
    input wire logic        dbg_port_enabled,
    input wire logic        sys_reset_n,
    input wire logic        io_tristate,
    input wire logic        droop_force_on,
    input wire logic        droop_lowest_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    a_swrst_fast: assert property (avs_write && avs_address == 4'hc
        && avs_writedata[0] |-> ##[1:2] !sys_reset_n)
        else $error("soft reset late");
    a_pins_float: assert property (io_tristate == !sys_reset_n)
        else $error("tristate not tied to reset");
    a_por_holds: assert property (por_req |-> ##[0:1] !sys_reset_n)
        else $error("reset not held by request");
    a_droop_forced: assert property (!droop_enabled
        && (chip_erase || dbg_port_enabled)
        |-> droop_force_on && droop_lowest_level)
        else $error("droop detector not forced");
    a_gate_off: assert property (!periph_clk_en |-> periph_gate_en == 8'h00)
        else $error("peripheral clock leaks");
    // Idle keeps every peripheral clock, counter included
    a_rtc_sleep: assert property (rtc_clk_en && !periph_clk_en |-> rtc_enabled)
        else $error("counter clock without enable");
    // Reset release also drops stall; its hold is far longer
    a_wake_stall: assert property ($fell(cpu_stall) |-> $past(cpu_stall, 4))
        else $error("stall shorter than four");
    a_idle_wake: assert property (sys_reset_n && !cpu_clk_en
        && periph_clk_en && irq_any |-> ##[1:6] cpu_clk_en)
        else $error("idle did not wake");
endmodule
////////////////////////////////////////////////////////////////////////////
bind slrc_top slrc_asserts i_chk (.clk, .resetn, .avs_address, .avs_write,
    .avs_writedata, .irq_any, .rtc_enabled, .cpu_stall, .cpu_clk_en,
    .periph_clk_en, .rtc_clk_en, .periph_gate_en, .por_req, .droop_enabled,
    .chip_erase, .dbg_port_enabled, .sys_reset_n, .io_tristate,
    .droop_force_on, .droop_lowest_level);

/* tb/slrc_osc_model.sv */
// Oscillator model: startup and calibration done flags
`timescale 1ns/1ns
module slrc_osc_model #(
    parameter int UP_CYC  = 8,
    parameter int CAL_DLY = 4
) (
    input  wire logic clk,
    input  wire logic io_tristate,
    output logic      osc_ready,
    output logic      osc_cal_done
);
    int cnt;
    // Held at zero while the device runs; counts up while io_tristate shows it is in reset
    always @(posedge clk) begin
        if (!io_tristate) cnt <= 0;
        else if (cnt < 255) cnt <= cnt + 1;
    end
    assign osc_ready    = io_tristate && cnt >= UP_CYC;
    assign osc_cal_done = io_tristate && cnt >= UP_CYC + CAL_DLY;
endmodule

/* tb/tb.sv */
// Self-checking bench for the sleep and reset controller
`timescale 1ns/1ns
module tb;
    logic clk, resetn, rd_, wr_, slp, nvm, ia, itw, ipa, iusb, irtc, idsp;
    logic rtc_en, dsp_en, por, extn, drq, den, cer, dbe, dbr, wdt;
    logic [3:0] adr;
    logic [31:0] wd, rdt, q;
    logic wrq, stall, take, cpuc, nvmc, perc, rtcc, dspc, sosc, srn, tri_;
    logic ffo, fll, fst, ordy, ocal;
    logic [7:0] gate;
    logic [15:0] vec;
    int failures, n_compared;
    slrc_top i_dut (.clk(clk), .resetn(resetn), .avs_address(adr),
        .avs_read(rd_), .avs_write(wr_), .avs_writedata(wd),
        .avs_readdata(rdt), .avs_waitrequest(wrq), .sleep_instr(slp),
        .nvm_busy(nvm), .irq_any(ia), .irq_twi_match(itw),
        .irq_port_async(ipa), .irq_usb_resume(iusb), .irq_rtc(irtc),
        .irq_display(idsp), .rtc_enabled(rtc_en), .display_enabled(dsp_en),
        .cpu_stall(stall), .wake_irq_take(take), .cpu_clk_en(cpuc),
        .nvm_clk_en(nvmc), .periph_clk_en(perc), .rtc_clk_en(rtcc),
        .display_clk_en(dspc), .sysosc_run(sosc), .periph_gate_en(gate),
        .por_req(por), .ext_reset_pin_n(extn), .droop_req(drq),
        .droop_enabled(den), .chip_erase(cer), .dbg_port_enabled(dbe),
        .dbg_reset_req(dbr), .wdt_timeout(wdt), .osc_ready(ordy),
        .osc_cal_done(ocal), .sys_reset_n(srn), .io_tristate(tri_),
        .droop_force_on(ffo), .droop_lowest_level(fll), .fetch_start(fst),
        .reset_vector(vec));
    slrc_osc_model i_osc (.clk(clk), .io_tristate(tri_), .osc_ready(ordy),
        .osc_cal_done(ocal));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    // Bus access; waitrequest is honoured though the slave never stalls
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        int i;
        adr <= a; wd <= d; wr_ <= w; rd_ <= !w;
        i = 0;
        do begin @(posedge clk); i++; end while (wrq !== 1'b0 && i < 50);
        q = rdt;
        if (i >= 50) begin failures++; wrap_up(); end
        wr_ <= 0; rd_ <= 0;
        // Let an edge pass so a following call never reassigns at once
        @(posedge clk);
    endtask
    task automatic wait_run;
        int i, f;
        f = 0;
        for (i = 0; i < 400 && srn !== 1'b1; i++) begin
            @(posedge clk);
            f += (fst === 1'b1);
        end
        if (i >= 400) begin failures++; wrap_up(); end
        chk("fetch", 1, f);
        cyc(2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_sleep;
        logic [2:0] m [5] = '{slrc_pkg::MODE_IDLE, slrc_pkg::MODE_PDOWN,
            slrc_pkg::MODE_PSAVE, slrc_pkg::MODE_STBY, slrc_pkg::MODE_ESTBY};
        logic [2:0] e [5] = '{3'h7, 3'h0, 3'h2, 3'h4, 3'h6};
        int i, k, tk;
        bus(1, slrc_pkg::ADDR_SLEEP_CTRL, 32'h0);
        slp <= 1; cyc(1); slp <= 0; cyc(3);
        chk("no_enable", 1, cpuc);
        for (k = 0; k < 5; k++) begin
            bus(1, slrc_pkg::ADDR_SLEEP_CTRL, {28'h0, m[k], 1'b1});
            slp <= 1; cyc(1); slp <= 0; cyc(3);
            chk("cpu_clk", 0, cpuc);
            chk("osc_rtc_per", e[k], {sosc, rtcc, perc});
            chk("nvm_clk", 0, nvmc);
            chk("dsp_clk", (k == 0), dspc);
            if (k > 0) begin
                ia <= 1; cyc(5);
                chk("irq_ignored", 0, cpuc);
            end
            ipa <= (k > 0);
            ia <= 1;
            tk = 0;
            for (i = 0; i < 30 && stall !== 1'b0; i++) begin
                cyc(1);
                tk += (take === 1'b1);
            end
            chk("woke", 0, stall);
            chk("take", 1, tk);
            ia <= 0; ipa <= 0; cyc(2);
        end
    endtask
    task automatic t_gate;
        bus(1, slrc_pkg::ADDR_PWR_RED, 32'h0f); cyc(1);
        chk("gate", 32'hf0, gate);
        bus(0, 4'h2, 32'h0);
        chk("unmapped", 0, q);
        bus(1, slrc_pkg::ADDR_RST_CTRL, 32'h2); cyc(1);
        chk("boot_vec", slrc_pkg::BOOT_VECTOR, vec);
    endtask
    task automatic t_ext;
        int i, lo;
        extn <= 0; cyc(20); extn <= 1; cyc(4);
        chk("short_pin", 1, srn);
        extn <= 0; cyc(60); lo = 0;
        for (i = 0; i < 30; i++) begin cyc(1); lo += (srn === 1'b0); end
        chk("held_low", 30, lo);
        extn <= 1; wait_run();
    endtask
    task automatic t_wdt;
        wdt <= 1; cyc(13); wdt <= 0; cyc(3);
        chk("wdt_rst", 0, srn);
        wait_run();
        dbr <= 1; cyc(2); dbr <= 0; wait_run();
    endtask
    task automatic t_swrst;
        bus(1, slrc_pkg::ADDR_RST_CTRL, 32'h1); cyc(1);
        chk("sw_rst", 0, srn);
        cyc(70); drq <= 1; cyc(2); drq <= 0;
        wait_run();
        chk("vec0", slrc_pkg::APP_VECTOR, vec);
        bus(0, slrc_pkg::ADDR_RST_STAT, 32'h0);
        chk("flags", 32'h3f, q);
    endtask
    task automatic t_droop;
        den <= 0; dbe <= 1; cyc(2);
        chk("force", 3, {ffo, fll});
        dbe <= 0; cer <= 1; cyc(2);
        chk("erase", 3, {ffo, fll});
        cer <= 0; den <= 1;
        por <= 1; cyc(3);
        chk("por_rst", 0, srn);
        por <= 0; wait_run();
        bus(0, slrc_pkg::ADDR_RST_STAT, 32'h0);
        chk("por_flags", 32'h01, q);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        {resetn, rd_, wr_, slp, nvm, ia, itw, ipa, iusb, irtc, idsp} = 0;
        {por, drq, cer, dbe, dbr, wdt, dsp_en} = 0;
        {rtc_en, extn, den} = 3'b111;
        adr = 0; wd = 0; failures = 0; n_compared = 0;
        cyc(10); resetn <= 1; wait_run();
        t_sleep(); t_gate(); t_ext(); t_wdt(); t_swrst(); t_droop();
        wrap_up();
    end
endmodule
